/* File: rtl/hfab_bridge.sv */
// Purpose: host to flash-bus bridge with register file on classic Wishbone
// Assumes: host cycle logic and flash-bus controller run on mclk
// Notes:   one flash transaction at a time, host and controller share the bus
//
// Function
// - only LPC memory, firmware-hub and indirect byte cycles reach the flash bus
// - a translated access goes to flash only if its region is unprotected
// - host writes are refused until firmware sets host_write_allow
// - FFC0_0000h to 4 GB top is the protected-mode BIOS window, 4 MB max
// - part of that window beyond the configured flash size is out of range
// - 64 KB at 000F_0000h legacy window, 64 KB at 000E_0000h extended
// - several host windows may alias the same flash bytes
// - some windows always mapped, others only while their enable is set
// - LPC memory and firmware-hub cycles accepted only while their enable is set
// - flash is reachable from both host and embedded controller, taking turns
// - extended legacy window served only while bios_extension_enable is set
// - indirect address is the four indirect address bytes, byte 3 on top
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "hfab_consts.svh"

module hfab_bridge (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // classic wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // host cycle port
  input  wire logic                     host_valid,
  input  wire hfab_pkg::hfab_host_req_s host_req,
  output hfab_pkg::hfab_host_rsp_s      host_rsp,
  // embedded controller port, 64 KB code space at flash offset 0
  input  wire logic                     ec_valid,
  input  wire logic [15:0]              ec_addr,
  output logic                          ec_done,
  output logic      [7:0]               ec_rdata,
  // flash bus
  output logic                          flash_valid,
  output hfab_pkg::hfab_flash_req_s     flash_req,
  input  wire logic                     flash_ack,
  input  wire logic [7:0]               flash_rdata,
  // zone timing for the flash controller
  output logic      [7:0]               main_zone_cfg,
  output logic      [7:0]               secondary_zone_cfg
);

  // register state
  logic                    host_write_allow;
  logic                    host_rd_err;
  logic                    host_wr_err;
  logic [7:0]              shared_memory_control;
  logic [2:0]              flash_size_select;
  logic [7:0]              indirect_address_bytes [4];
  logic [7:0]              rd_prot;
  logic [7:0]              wr_prot;

  // bridge state
  hfab_pkg::hfab_state_e   state;
  hfab_pkg::hfab_host_req_s cur;
  logic [31:0]             eff_addr;
  logic                    win_hit;
  logic [21:0]             win_addr;
  logic                    path_en;
  logic                    prot_hit;
  logic                    accept_host;
  logic                    forbid;
  logic                    set_rd_err;
  logic                    set_wr_err;
  logic                    wb_req;
  logic                    wb_wr;
  logic [7:0]              wb_byte;

  // byte-lane 0 write helper
  function automatic logic lane0_write(input logic wr, input logic [7:0] adr,
                                       input logic [7:0] ofs);
    lane0_write = wr && (adr == ofs);
  endfunction : lane0_write

  // protection bit of a flash offset, one bit per 512 KB block
  function automatic logic prot_bit(input logic [7:0] mask, input logic [21:0] fa);
    prot_bit = mask[fa[`HFAB_PROT_BLK_MSB:`HFAB_PROT_BLK_LSB]];
  endfunction : prot_bit

  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
  assign wb_byte = wb_dat_i[7:0];

  // indirect cycles take the address from the register bytes
  assign eff_addr = (host_req.kind == hfab_pkg::HFAB_KIND_INDIRECT)
                  ? {indirect_address_bytes[3], indirect_address_bytes[2],
                     indirect_address_bytes[1], indirect_address_bytes[0]}
                  : host_req.addr;

  hfab_window_decode u_decode (
    .host_addr   (eff_addr),
    .size_sel    (flash_size_select),
    .bios_ext_en (shared_memory_control[`HFAB_BIT_BIOS_EXT_EN]),
    .hit         (win_hit),
    .flash_addr  (win_addr)
  );

  // path enable per cycle kind; indirect follows the LPC memory path
  always_comb begin
    path_en = 1'b0;
    unique case (host_req.kind)
      hfab_pkg::HFAB_KIND_LPC_MEM:
        path_en = shared_memory_control[`HFAB_BIT_LPC_EN];
      hfab_pkg::HFAB_KIND_FWH:
        path_en = shared_memory_control[`HFAB_BIT_FWH_EN];
      hfab_pkg::HFAB_KIND_INDIRECT:
        path_en = shared_memory_control[`HFAB_BIT_LPC_EN];
      hfab_pkg::HFAB_KIND_NONE:
        path_en = 1'b0;
    endcase
  end

  // forbidden when the block is protected or writes are not yet allowed
  assign prot_hit = host_req.we ? prot_bit(wr_prot, win_addr)
                                : prot_bit(rd_prot, win_addr);
  assign forbid   = prot_hit || (host_req.we && !host_write_allow);
  assign accept_host = (state == hfab_pkg::HFAB_ST_IDLE) && host_valid;

  assign set_rd_err = accept_host && path_en && win_hit && forbid && !host_req.we;
  assign set_wr_err = accept_host && path_en && win_hit && forbid && host_req.we;

  // sequencer: host has priority when both ask in the same idle cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= hfab_pkg::HFAB_ST_IDLE;
    end else begin
      unique case (state)
        hfab_pkg::HFAB_ST_IDLE: begin
          if (host_valid) begin
            if (path_en && win_hit && !forbid) begin
              state <= hfab_pkg::HFAB_ST_HOST;
            end else begin
              state <= hfab_pkg::HFAB_ST_DONE;
            end
          end else if (ec_valid) begin
            state <= hfab_pkg::HFAB_ST_EC;
          end
        end
        hfab_pkg::HFAB_ST_HOST: begin
          if (flash_ack) begin
            state <= hfab_pkg::HFAB_ST_DONE;
          end
        end
        hfab_pkg::HFAB_ST_EC: begin
          if (flash_ack) begin
            state <= hfab_pkg::HFAB_ST_DONE;
          end
        end
        hfab_pkg::HFAB_ST_DONE: begin
          // gap so a held request is not taken twice after done
          state <= hfab_pkg::HFAB_ST_IDLE;
        end
      endcase
    end
  end

  // latch the flash request; held stable until flash_ack
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flash_valid <= 1'b0;
      flash_req   <= '0;
      cur         <= '0;
    end else begin
      if (accept_host) begin
        cur <= host_req;
      end
      if (accept_host && path_en && win_hit && !forbid) begin
        flash_valid     <= 1'b1;
        flash_req.addr  <= win_addr;
        flash_req.we    <= host_req.we;
        flash_req.wdata <= host_req.wdata;
      end else if ((state == hfab_pkg::HFAB_ST_IDLE) && !host_valid && ec_valid) begin
        flash_valid     <= 1'b1;
        flash_req.addr  <= {6'h00, ec_addr};
        flash_req.we    <= 1'b0;
        flash_req.wdata <= 8'h00;
      end else if (flash_ack) begin
        flash_valid <= 1'b0;
      end
    end
  end

  // host answer: one-cycle done pulse with its outcome and read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_rsp <= '0;
    end else begin
      host_rsp.done      <= 1'b0;
      host_rsp.ignored   <= 1'b0;
      host_rsp.forbidden <= 1'b0;
      if (accept_host && !(path_en && win_hit)) begin
        host_rsp.done    <= 1'b1;
        host_rsp.ignored <= 1'b1;
        host_rsp.rdata   <= 8'h00;
      end else if (accept_host && forbid) begin
        host_rsp.done      <= 1'b1;
        host_rsp.forbidden <= 1'b1;
        host_rsp.rdata     <= 8'h00;
      end else if ((state == hfab_pkg::HFAB_ST_HOST) && flash_ack) begin
        host_rsp.done  <= 1'b1;
        host_rsp.rdata <= cur.we ? 8'h00 : flash_rdata;
      end
    end
  end

  // controller answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ec_done  <= 1'b0;
      ec_rdata <= 8'h00;
    end else begin
      ec_done <= (state == hfab_pkg::HFAB_ST_EC) && flash_ack;
      if ((state == hfab_pkg::HFAB_ST_EC) && flash_ack) begin
        ec_rdata <= flash_rdata;
      end
    end
  end

  // control and status; a new error beats a same-cycle write-one clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_write_allow <= 1'b0;
      host_rd_err      <= 1'b0;
      host_wr_err      <= 1'b0;
    end else begin
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_CTRL_STATUS)) begin
        host_write_allow <= wb_byte[`HFAB_BIT_HOST_WR_ALLOW];
      end
      if (set_rd_err) begin
        host_rd_err <= 1'b1;
      end else if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_CTRL_STATUS)
                   && wb_byte[`HFAB_BIT_HOST_RD_ERR]) begin
        host_rd_err <= 1'b0;
      end
      if (set_wr_err) begin
        host_wr_err <= 1'b1;
      end else if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_CTRL_STATUS)
                   && wb_byte[`HFAB_BIT_HOST_WR_ERR]) begin
        host_wr_err <= 1'b0;
      end
    end
  end

  // mapping and zone configuration
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shared_memory_control <= `HFAB_RST_SHM_CTRL;
      flash_size_select     <= `HFAB_RST_FLASH_SIZE;
      main_zone_cfg         <= `HFAB_RST_ZONE;
      secondary_zone_cfg    <= `HFAB_RST_ZONE;
    end else begin
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_SHM_CTRL)) begin
        shared_memory_control <= wb_byte;
      end
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_FLASH_SIZE)) begin
        flash_size_select <= wb_byte[2:0];
      end
      // firmware is expected to load the fast zone settings here
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_MAIN_ZONE)) begin
        main_zone_cfg <= wb_byte;
      end
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_SEC_ZONE)) begin
        secondary_zone_cfg <= wb_byte;
      end
    end
  end

  // indirect address bytes and protection masks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_address_bytes[0] <= 8'h00;
      indirect_address_bytes[1] <= 8'h00;
      indirect_address_bytes[2] <= 8'h00;
      indirect_address_bytes[3] <= 8'h00;
      rd_prot                   <= `HFAB_RST_RD_PROT;
      wr_prot                   <= `HFAB_RST_WR_PROT;
    end else begin
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_IND_ADDR0)) begin
        indirect_address_bytes[0] <= wb_byte;
      end
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_IND_ADDR1)) begin
        indirect_address_bytes[1] <= wb_byte;
      end
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_IND_ADDR2)) begin
        indirect_address_bytes[2] <= wb_byte;
      end
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_IND_ADDR3)) begin
        indirect_address_bytes[3] <= wb_byte;
      end
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_RD_PROT)) begin
        rd_prot <= wb_byte;
      end
      if (lane0_write(wb_wr, wb_adr_i, `HFAB_OFS_WR_PROT)) begin
        wr_prot <= wb_byte;
      end
    end
  end

  // bus answer: ack one cycle after the strobe, read data from the same edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          `HFAB_OFS_CTRL_STATUS: wb_dat_o <= {28'h000_0000,
                                              state != hfab_pkg::HFAB_ST_IDLE,
                                              host_wr_err, host_rd_err,
                                              host_write_allow};
          `HFAB_OFS_SHM_CTRL:    wb_dat_o <= {24'h00_0000, shared_memory_control};
          `HFAB_OFS_FLASH_SIZE:  wb_dat_o <= {29'h0000_0000, flash_size_select};
          `HFAB_OFS_MAIN_ZONE:   wb_dat_o <= {24'h00_0000, main_zone_cfg};
          `HFAB_OFS_SEC_ZONE:    wb_dat_o <= {24'h00_0000, secondary_zone_cfg};
          `HFAB_OFS_IND_ADDR0:   wb_dat_o <= {24'h00_0000, indirect_address_bytes[0]};
          `HFAB_OFS_IND_ADDR1:   wb_dat_o <= {24'h00_0000, indirect_address_bytes[1]};
          `HFAB_OFS_IND_ADDR2:   wb_dat_o <= {24'h00_0000, indirect_address_bytes[2]};
          `HFAB_OFS_IND_ADDR3:   wb_dat_o <= {24'h00_0000, indirect_address_bytes[3]};
          `HFAB_OFS_RD_PROT:     wb_dat_o <= {24'h00_0000, rd_prot};
          `HFAB_OFS_WR_PROT:     wb_dat_o <= {24'h00_0000, wr_prot};
          default:               wb_dat_o <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

endmodule : hfab_bridge

/* File: rtl/hfab_consts.svh */
// Purpose: constants for the host flash address bridge
// Assumes: byte addresses on the register bus, 22-bit flash offsets (4 MB)
// Notes:   included by the bridge and window decoder design files, not by the package
`ifndef HFAB_CONSTS_SVH
`define HFAB_CONSTS_SVH

// register byte offsets
`define HFAB_OFS_CTRL_STATUS   8'h00
`define HFAB_OFS_SHM_CTRL      8'h04
`define HFAB_OFS_FLASH_SIZE    8'h08
`define HFAB_OFS_MAIN_ZONE     8'h0C
`define HFAB_OFS_SEC_ZONE      8'h10
`define HFAB_OFS_IND_ADDR0     8'h14
`define HFAB_OFS_IND_ADDR1     8'h18
`define HFAB_OFS_IND_ADDR2     8'h1C
`define HFAB_OFS_IND_ADDR3     8'h20
`define HFAB_OFS_RD_PROT       8'h24
`define HFAB_OFS_WR_PROT       8'h28

// control and status, then shared memory control bit positions
`define HFAB_BIT_HOST_WR_ALLOW 0
`define HFAB_BIT_HOST_RD_ERR   1
`define HFAB_BIT_HOST_WR_ERR   2
`define HFAB_BIT_HOST_BUSY     3
`define HFAB_BIT_LPC_EN        0
`define HFAB_BIT_FWH_EN        1
`define HFAB_BIT_BIOS_EXT_EN   2

// reset values
`define HFAB_RST_SHM_CTRL      8'h03
`define HFAB_RST_FLASH_SIZE    3'h5
`define HFAB_RST_ZONE          8'h00
`define HFAB_RST_RD_PROT       8'h00
`define HFAB_RST_WR_PROT       8'hFF

// host windows
`define HFAB_WIN386_BASE_HI    10'h3FF
`define HFAB_LEGACY_F_HI       16'h000F
`define HFAB_LEGACY_E_HI       16'h000E
`define HFAB_FULL_SIZE         23'h40_0000
`define HFAB_MIN_SIZE          23'h02_0000
`define HFAB_SIZE_SEL_MAX      3'h5
`define HFAB_WIN64K            23'h01_0000
`define HFAB_WIN128K           23'h02_0000
`define HFAB_PROT_BLK_MSB      21
`define HFAB_PROT_BLK_LSB      19

`endif

/* File: rtl/hfab_pkg.sv */
// Purpose: types shared by the bridge, its checker, flash model and bench
// Assumes: hfab_consts.svh holds all numbers
// Notes:   nothing here is imported, callers write hfab_pkg::name
package hfab_pkg;

  // host cycle kinds; all but HFAB_KIND_NONE may reach the flash bus
  typedef enum logic [1:0] {
    HFAB_KIND_LPC_MEM  = 2'b00,
    HFAB_KIND_FWH      = 2'b01,
    HFAB_KIND_INDIRECT = 2'b10,
    HFAB_KIND_NONE     = 2'b11
  } hfab_kind_e;

  typedef enum logic [1:0] {
    HFAB_ST_IDLE  = 2'b00,
    HFAB_ST_HOST  = 2'b01,
    HFAB_ST_EC    = 2'b10,
    HFAB_ST_DONE  = 2'b11
  } hfab_state_e;

  typedef struct packed {
    hfab_kind_e  kind;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } hfab_host_req_s;

  typedef struct packed {
    logic [21:0] addr;
    logic        we;
    logic [7:0]  wdata;
  } hfab_flash_req_s;

  typedef struct packed {
    logic        done;
    logic        ignored;
    logic        forbidden;
    logic [7:0]  rdata;
  } hfab_host_rsp_s;

endpackage : hfab_pkg

/* File: rtl/hfab_window_decode.sv */
// Purpose: decode a host address into a window and a flash offset
// Assumes: BIOS windows sit at the top of the flash
// Notes:   purely combinational, used once per host request
`timescale 1ns/1ps
`include "hfab_consts.svh"

module hfab_window_decode (
  input  wire logic [31:0] host_addr,
  input  wire logic [2:0]  size_sel,
  input  wire logic        bios_ext_en,
  output logic             hit,
  output logic [21:0]      flash_addr
);

  logic [2:0]  sel_cap;
  logic [22:0] flash_size;
  logic [22:0] gap;
  logic [22:0] off386;
  logic        in386;
  logic        in_f;
  logic        in_e;

  // size in bytes; larger codes clamp to the full 4 MB window
  assign sel_cap    = (size_sel > `HFAB_SIZE_SEL_MAX) ? `HFAB_SIZE_SEL_MAX : size_sel;
  assign flash_size = `HFAB_MIN_SIZE << sel_cap;
  assign gap        = `HFAB_FULL_SIZE - flash_size;
  assign off386     = {1'b0, host_addr[21:0]};

  // protected-mode window below 4 GB, lower part out of range on small parts
  assign in386 = (host_addr[31:22] == `HFAB_WIN386_BASE_HI) && (off386 >= gap);
  assign in_f  = (host_addr[31:16] == `HFAB_LEGACY_F_HI);
  assign in_e  = (host_addr[31:16] == `HFAB_LEGACY_E_HI) && bios_ext_en;

  // the 386 and F windows end at the flash top and E sits just below F, so windows alias
  always_comb begin
    hit        = 1'b0;
    flash_addr = '0;
    if (in386) begin
      hit        = 1'b1;
      flash_addr = 22'(off386 - gap);
    end else if (in_f) begin
      hit        = 1'b1;
      flash_addr = 22'(flash_size - `HFAB_WIN64K + {7'h00, host_addr[15:0]});
    end else if (in_e) begin
      hit        = 1'b1;
      flash_addr = 22'(flash_size - `HFAB_WIN128K + {7'h00, host_addr[15:0]});
    end
  end

endmodule : hfab_window_decode

/* File: tb/hfab_bridge_chk.sv */
// Purpose: port checks for the flash bridge
// Assumes: one clock, async low reset
// Notes:   bound to hfab_bridge from the bench top
`timescale 1ns/1ps
module hfab_bridge_chk (
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_ack_o,
  input wire logic                      host_valid,
  input wire hfab_pkg::hfab_host_req_s  host_req,
  input wire hfab_pkg::hfab_host_rsp_s  host_rsp,
  input wire logic                      ec_done,
  input wire logic                      flash_valid,
  input wire hfab_pkg::hfab_flash_req_s flash_req,
  input wire logic                      flash_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ack one cycle after the request, for one cycle
  a_wb_ack_lat: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_wb_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  // flash request stands until ack, then drops
  a_flash_hold: assert property (flash_valid && !flash_ack |=> flash_valid && $stable(flash_req))
    else $error("flash req moved");
  a_flash_drop: assert property (flash_valid && flash_ack |=> !flash_valid)
    else $error("flash req held");
  // the controller only reads, so a flash write is a host write
  a_flash_wr_src: assert property (
    $rose(flash_valid) && flash_req.we |-> $past(host_valid && host_req.we))
    else $error("stray flash write");
  // forwarded answers follow a flash ack by one cycle
  a_host_fwd_done: assert property (
    host_rsp.done && !host_rsp.ignored && !host_rsp.forbidden |-> $past(flash_ack))
    else $error("stray host done");
  a_ec_done: assert property (ec_done |-> $past(flash_ack))
    else $error("stray ec done");
  // refused cycles finish without a flash transaction
  a_refuse_idle: assert property (
    host_rsp.ignored || host_rsp.forbidden |-> host_rsp.done && !flash_valid)
    else $error("refused cycle forwarded");
  a_kind_none: assert property (
    host_rsp.done && $past(host_valid && host_req.kind == hfab_pkg::HFAB_KIND_NONE)
    |-> host_rsp.ignored)
    else $error("no-kind cycle kept");
  c_fwd: cover property (host_rsp.done && !host_rsp.ignored && !host_rsp.forbidden);
  c_ign: cover property (host_rsp.ignored);
  c_forb: cover property (host_rsp.forbidden);
  c_ec: cover property (ec_done);
endmodule : hfab_bridge_chk

/* File: tb/hfab_flash_model.sv */
// Purpose: flash controller seen from the bridge
// Assumes: one ack per request, after 0 to 3 wait cycles
// Notes:   read data is a pure function of the offset
`timescale 1ns/1ps
module hfab_flash_model (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [1:0]                delay,
  input  wire logic                      flash_valid,
  input  wire hfab_pkg::hfab_flash_req_s flash_req,
  output logic                           flash_ack,
  output logic [7:0]                     flash_rdata,
  output logic [15:0]                    txn_count,
  output hfab_pkg::hfab_flash_req_s      last_req
);
  logic [1:0] wait_cnt;
  // one ack per request once delay wait cycles have passed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flash_ack   <= 1'b0;
      flash_rdata <= 8'h00;
      txn_count   <= 16'h0000;
      last_req    <= '0;
      wait_cnt    <= 2'h0;
    end else begin
      if (flash_valid && !flash_ack && wait_cnt == delay) begin
        flash_ack   <= 1'b1;
        flash_rdata <= flash_req.addr[7:0] ^ flash_req.addr[15:8] ^ {2'h0, flash_req.addr[21:16]};
        txn_count   <= txn_count + 16'h0001;
        last_req    <= flash_req;
        wait_cnt    <= 2'h0;
      end else begin
        flash_ack   <= 1'b0;
        flash_rdata <= ~flash_rdata; // no stale data outside the ack cycle
        wait_cnt    <= (flash_valid && !flash_ack) ? wait_cnt + 2'h1 : 2'h0;
      end
    end
  end
endmodule : hfab_flash_model

/* File: tb/hfab_bridge_test.sv */
// Purpose: random and corner checks of the flash bridge
// Assumes: flash model answers after a random wait
// Notes:   expectations come from the bench's own window arithmetic
`timescale 1ns/1ps
module hfab_bridge_test;
  logic mclk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic host_valid = 1'b0, ec_valid = 1'b0, wb_ack_o, ec_done, flash_valid, flash_ack;
  logic [7:0]  wb_adr_i = 8'h00, ec_rdata, flash_rdata, main_zone_cfg, secondary_zone_cfg;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, a, q;
  logic [15:0] ec_addr = 16'h0, txn_count;
  logic [1:0]  delay = 2'h0, err_m;
  logic [2:0]  sel_m;
  logic [7:0]  shm_m, rp_m, wp_m;
  logic        allow_m;
  int          fail_count = 0, total_checks = 0, cycles = 0;
  hfab_pkg::hfab_host_req_s  host_req = '0;
  hfab_pkg::hfab_host_rsp_s  host_rsp;
  hfab_pkg::hfab_flash_req_s flash_req, last_req;

  hfab_bridge i_hfab_bridge (.*);
  hfab_flash_model i_hfab_flash_model (.*);

  // 50 MHz clock and a hang guard well above the expected run
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do
      @(posedge mclk);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask : wb

  function automatic logic [22:0] fsize();
    return 23'h02_0000 << ((sel_m > 3'h5) ? 3'h5 : sel_m);
  endfunction : fsize

  function automatic logic [7:0] fdat(input logic [21:0] x);
    return x[7:0] ^ x[15:8] ^ {2'h0, x[21:16]};
  endfunction : fdat

  // outcome 0 forwarded, 1 ignored, 2 forbidden
  function automatic logic [1:0] predict(input logic [1:0] k, input logic we,
                                         input logic [31:0] x, output logic [21:0] off);
    logic [22:0] sz;
    logic        hit;
    sz  = fsize();
    off = 22'h00_0000;
    hit = 1'b1;
    if (x[31:22] == 10'h3FF && {1'b0, x[21:0]} >= 23'h40_0000 - sz)
      off = 22'(x[21:0] - (23'h40_0000 - sz));
    else if (x[31:16] == 16'h000F)
      off = 22'(sz - 23'h01_0000 + x[15:0]);
    else if (x[31:16] == 16'h000E && shm_m[2])
      off = 22'(sz - 23'h02_0000 + x[15:0]);
    else
      hit = 1'b0;
    if (k == 2'h3 || !(k == 2'h1 ? shm_m[1] : shm_m[0]) || !hit)
      return 2'h1;
    if ((we ? wp_m[off[21:19]] : rp_m[off[21:19]]) || (we && !allow_m))
      return 2'h2;
    return 2'h0;
  endfunction : predict

  // protection, size, enables, write allow; also clears both error flags
  task automatic cfg();
    wb(1'b1, 8'h24, {24'h0, rp_m}, q);
    wb(1'b1, 8'h28, {24'h0, wp_m}, q);
    wb(1'b1, 8'h08, {29'h0, sel_m}, q);
    wb(1'b1, 8'h04, {24'h0, shm_m}, q);
    wb(1'b1, 8'h00, {29'h0, 2'h3, allow_m}, q);
    err_m = 2'h0;
  endtask : cfg

  // one host cycle with every visible consequence compared
  task automatic run_op(input logic [1:0] k, input logic we, input logic [31:0] x);
    logic [21:0] off;
    logic [1:0]  res;
    logic [7:0]  wd;
    logic [15:0] n0;
    wd  = 8'($urandom);
    res = predict(k, we, x, off);
    if (k == 2'h2) begin
      for (int i = 0; i < 4; i++)
        wb(1'b1, 8'h14 + 8'(4 * i), {24'h0, x[8*i +: 8]}, q);
      x = ~x;
    end
    n0 = txn_count;
    delay      <= 2'($urandom);
    host_valid <= 1'b1;
    host_req   <= '{hfab_pkg::hfab_kind_e'(k), we, x, wd};
    do
      @(posedge mclk);
    while (host_rsp.done !== 1'b1);
    host_valid <= 1'b0;
    chk("outcome", {30'h0, res}, {30'h0, host_rsp.forbidden, host_rsp.ignored});
    chk("rdata", {24'h0, (res == 2'h0 && !we) ? fdat(off) : 8'h00}, {24'h0, host_rsp.rdata});
    @(posedge mclk);
    chk("flash count", {16'h0, (res == 2'h0) ? n0 + 16'h1 : n0}, {16'h0, txn_count});
    if (res == 2'h0)
      chk("flash req", {off, we, we ? wd : 8'h00},
          {last_req.addr, last_req.we, we ? last_req.wdata : 8'h00});
    if (res == 2'h2)
      err_m[we] = 1'b1;
    wb(1'b0, 8'h00, 32'h0, q);
    chk("status", {28'h000_0000, 1'b0, err_m, allow_m}, q);
  endtask : run_op

  task automatic ec_op();
    ec_addr  <= 16'($urandom);
    ec_valid <= 1'b1;
    do
      @(posedge mclk);
    while (ec_done !== 1'b1);
    ec_valid <= 1'b0;
    chk("ec rdata", {24'h0, fdat({6'h00, ec_addr})}, {24'h0, ec_rdata});
    @(posedge mclk);
    chk("ec single txn", 32'h0, {31'h0, flash_valid});
  endtask : ec_op

  // reset values, zone setup, aliasing corners, then random traffic
  initial begin
    void'($urandom(32'h62d0_df7c));
    sel_m   = 3'h5;
    shm_m   = 8'h03;
    rp_m    = 8'h00;
    wp_m    = 8'hFF;
    allow_m = 1'b0;
    err_m   = 2'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    wb(1'b1, 8'h30, 32'hFFFF_FFFF, q);
    wb_sel_i <= 4'hE;
    wb(1'b1, 8'h28, 32'h0, q); // lane 0 off: write dropped
    wb_sel_i <= 4'hF;
    for (int i = 0; i < 13; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0, q);
      chk("reset value", (i == 1) ? 32'h3 : (i == 2) ? 32'h5 : (i == 10) ? 32'hFF : 32'h0, q);
    end
    wb(1'b1, 8'h0C, 32'h0, q);
    wb(1'b1, 8'h10, 32'h8, q);
    chk("zone cfg", 32'h8, {16'h0, main_zone_cfg, secondary_zone_cfg});
    run_op(2'h0, 1'b0, 32'h000F_1234);
    run_op(2'h1, 1'b0, 32'hFFFF_1234);
    run_op(2'h0, 1'b0, 32'h000E_1234);
    run_op(2'h1, 1'b1, 32'hFFC0_0000);
    run_op(2'h3, 1'b0, 32'h000F_0000);
    ec_op();
    for (int t = 0; t < 80; t++) begin
      sel_m   = 3'($urandom);
      shm_m   = 8'($urandom_range(7));
      rp_m    = 8'($urandom & $urandom & $urandom);
      wp_m    = 8'($urandom & $urandom);
      allow_m = 1'($urandom);
      cfg();
      a = $urandom;
      case ($urandom_range(3))
        0: a[31:22] = 10'h3FF;
        1: a[31:16] = 16'h000F;
        2: a[31:16] = 16'h000E;
        default: ;
      endcase
      if (a[31:22] == 10'h3FF && $urandom_range(1) == 1)
        a[21:0] = 22'(23'h40_0000 - fsize() - 23'(t % 2));
      run_op(2'($urandom), 1'($urandom), a);
      if (t % 8 == 0)
        ec_op();
    end
    stop_test();
  end
endmodule : hfab_bridge_test

bind hfab_bridge hfab_bridge_chk i_hfab_bridge_chk (.*);
